// ---- hdl/trp_pkg.sv ----
// Shared constants and carrier types for the timing report framer
package trp_pkg;

  // Frame bytes
  localparam logic [7:0] DLE        = 8'h10;
  localparam logic [7:0] ETX        = 8'h03;
  localparam logic [7:0] MSG_ID     = 8'hA1;
  localparam logic [7:0] SUB_TIME   = 8'h00;
  localparam logic [7:0] SUB_UTC    = 8'h01;
  localparam logic [7:0] SUB_CORR   = 8'h02;
  localparam logic [7:0] MODE_QUERY = 8'h00;
  localparam logic [7:0] MODE_RESP  = 8'h02;
  localparam logic [7:0] TYPE_CFG   = 8'hFF;
  localparam logic [2:0] CONST_LAST = 3'h4;

  // Length field values: mode + payload + checksum
  localparam logic [15:0] LEN_QUERY_PLAIN = 16'h0002;
  localparam logic [15:0] LEN_QUERY_UTC   = 16'h0003;
  localparam logic [15:0] LEN_QUERY_MAX   = 16'h0008;
  localparam logic [15:0] LEN_TIME_RESP   = 16'h0020;
  localparam logic [15:0] LEN_UTC_RESP    = 16'h0013;

  // Payload geometry, in bytes, and the largest seconds into week
  localparam logic [5:0] PAY_IDX_FIRST  = 6'h06;
  localparam logic [5:0] PAY_TIME_BYTES = 6'h1E;
  localparam logic [5:0] PAY_UTC_BYTES  = 6'h11;
  localparam int         PAY_MAX_BYTES  = 30;
  localparam logic [31:0] WEEK_SEC_MAX  = 32'h0009_3A7F;

  // Register map
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic [7:0]  REG_COUNT  = 8'h08;
  localparam int          CTRL_AUTO_BIT = 0;
  localparam int          CTRL_OSC_BIT  = 1;
  localparam int          CTRL_TB_LSB   = 4;
  localparam int          CTRL_EN_LSB   = 8;
  localparam logic [31:0] CTRL_MASK     = 32'h0000_1F73;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0101;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_ID   = 3'b001,
    RX_SUB  = 3'b010,
    RX_LENH = 3'b011,
    RX_LENL = 3'b100,
    RX_BODY = 3'b101,
    RX_END1 = 3'b110,
    RX_END2 = 3'b111
  } trp_rx_state_t;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } trp_tx_state_t;

  typedef struct packed {
    logic [7:0] sub;
    logic [7:0] qtype;
  } trp_query_t;

  typedef struct packed {
    logic [31:0] seconds_into_week;
    logic [15:0] week;
    logic [7:0]  hour;
    logic [7:0]  minute;
    logic [7:0]  second;
    logic [7:0]  month;
    logic [7:0]  day;
    logic [15:0] year;
    logic        time_utc;
    logic [2:0]  time_base;
    logic        pps_utc;
    logic [2:0]  pps_base;
    logic        time_valid;
    logic        utc_valid;
    logic [15:0] utc_offset;
    logic [31:0] quant_err;
    logic [31:0] bias;
    logic [31:0] bias_rate;
  } trp_time_rpt_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] week;
    logic [31:0] seconds_into_week;
    logic [7:0]  leap_second_delta;
    logic [63:0] offset_ns;
  } trp_utc_par_t;

endpackage

// ---- hdl/trp_rx_parser.sv ----
// Query frame parser for the host link
`timescale 1ns/1ps
`default_nettype none

module trp_rx_parser (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic [7:0]         rx_data_i,
  input  wire logic               rx_valid_i,
  output var  trp_pkg::trp_query_t query_o,
  output logic                    query_valid_o,
  output logic                    error_o
);

  trp_pkg::trp_rx_state_t state, next_state;
  logic [7:0]  sub, next_sub, mode, next_mode, qtype, next_qtype;
  logic [7:0]  xsum, next_xsum, chk, next_chk;
  logic [15:0] len, next_len;
  logic [15:0] cnt, next_cnt;
  logic        next_query_valid, next_error;
  logic [15:0] len_expect;

  assign len_expect = (sub == trp_pkg::SUB_UTC) ? trp_pkg::LEN_QUERY_UTC : trp_pkg::LEN_QUERY_PLAIN;

  always_comb begin
    next_state       = state;
    next_sub         = sub;
    next_mode        = mode;
    next_qtype       = qtype;
    next_xsum        = xsum;
    next_chk         = chk;
    next_len         = len;
    next_cnt         = cnt;
    next_query_valid = 1'b0;
    next_error       = 1'b0;
    if (rx_valid_i) begin
      case (state)
        trp_pkg::RX_IDLE: begin
          if (rx_data_i == trp_pkg::DLE) next_state = trp_pkg::RX_ID;
        end
        trp_pkg::RX_ID: begin
          // Other message families belong to other blocks
          if (rx_data_i == trp_pkg::MSG_ID) begin
            next_xsum  = rx_data_i;
            next_state = trp_pkg::RX_SUB;
          end else begin
            next_state = trp_pkg::RX_IDLE;
          end
        end
        trp_pkg::RX_SUB: begin
          next_sub   = rx_data_i;
          next_qtype = 8'h00;
          next_xsum  = xsum ^ rx_data_i;
          next_state = trp_pkg::RX_LENH;
        end
        trp_pkg::RX_LENH: begin
          next_len   = {rx_data_i, 8'h00};
          next_xsum  = xsum ^ rx_data_i;
          next_state = trp_pkg::RX_LENL;
        end
        trp_pkg::RX_LENL: begin
          next_len  = {len[15:8], rx_data_i};
          next_xsum = xsum ^ rx_data_i;
          next_cnt  = 16'h0000;
          // Bounded so a corrupt length cannot swallow the link
          if ({len[15:8], rx_data_i} < trp_pkg::LEN_QUERY_PLAIN ||
              {len[15:8], rx_data_i} > trp_pkg::LEN_QUERY_MAX) begin
            next_error = 1'b1;
            next_state = trp_pkg::RX_IDLE;
          end else begin
            next_state = trp_pkg::RX_BODY;
          end
        end
        trp_pkg::RX_BODY: begin
          next_cnt = cnt + 16'h0001;
          if (cnt == 16'h0000) next_mode = rx_data_i;
          if (cnt == 16'h0001) next_qtype = rx_data_i;
          if (cnt == len - 16'h0001) begin
            next_chk   = rx_data_i;
            next_state = trp_pkg::RX_END1;
          end else begin
            next_xsum = xsum ^ rx_data_i;
          end
        end
        trp_pkg::RX_END1: begin
          if (rx_data_i == trp_pkg::DLE) begin
            next_state = trp_pkg::RX_END2;
          end else begin
            next_error = 1'b1;
            next_state = trp_pkg::RX_IDLE;
          end
        end
        trp_pkg::RX_END2: begin
          next_state = trp_pkg::RX_IDLE;
          if (rx_data_i == trp_pkg::ETX && chk == xsum && mode == trp_pkg::MODE_QUERY &&
              len == len_expect && sub <= trp_pkg::SUB_CORR) begin
            next_query_valid = 1'b1;
          end else begin
            next_error = 1'b1;
          end
        end
        default: next_state = trp_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state         <= trp_pkg::RX_IDLE;
      sub           <= 8'h00;
      mode          <= 8'h00;
      qtype         <= 8'h00;
      xsum          <= 8'h00;
      chk           <= 8'h00;
      len           <= 16'h0000;
      cnt           <= 16'h0000;
      query_valid_o <= 1'b0;
      error_o       <= 1'b0;
    end else begin
      state         <= next_state;
      sub           <= next_sub;
      mode          <= next_mode;
      qtype         <= next_qtype;
      xsum          <= next_xsum;
      chk           <= next_chk;
      len           <= next_len;
      cnt           <= next_cnt;
      query_valid_o <= next_query_valid;
      error_o       <= next_error;
    end
  end

  assign query_o = '{sub: sub, qtype: qtype};

endmodule

`default_nettype wire

// ---- hdl/trp_tx_stage.sv ----
// Transmit byte register with running checksum
`timescale 1ns/1ps
`default_nettype none

module trp_tx_stage (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       valid_i,
  input  wire logic       chk_en_i,
  input  wire logic       clr_i,
  output logic            ready_o,
  output logic [7:0]      chk_o,
  output logic [7:0]      tx_data_o,
  output logic            tx_valid_o,
  input  wire logic       tx_ready_i
);

  logic [7:0] next_data, next_chk;
  logic       next_valid, take;

  assign ready_o = ~tx_valid_o | tx_ready_i;
  assign take    = valid_i & ready_o;

  always_comb begin
    next_valid = take | (tx_valid_o & ~tx_ready_i);
    next_data  = take ? byte_i : tx_data_o;
    next_chk   = chk_o;
    if (clr_i) begin
      next_chk = 8'h00;
    end else if (take && chk_en_i) begin
      next_chk = chk_o ^ byte_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_data_o  <= 8'h00;
      tx_valid_o <= 1'b0;
      chk_o      <= 8'h00;
    end else begin
      tx_data_o  <= next_data;
      tx_valid_o <= next_valid;
      chk_o      <= next_chk;
    end
  end

endmodule

`default_nettype wire

// ---- hdl/trp_framer.sv ----
// Timing report framer: query parsing, response framing, register slave
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module trp_framer #(
  parameter int NUM_CONST = 5
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic [7:0]             rx_data_i,
  input  wire logic                   rx_valid_i,
  output logic [7:0]                  tx_data_o,
  output logic                        tx_valid_o,
  input  wire logic                   tx_ready_i,
  input  wire logic                   pps_i,
  input  wire trp_pkg::trp_time_rpt_t time_i,
  input  wire trp_pkg::trp_utc_par_t  [NUM_CONST-1:0] utc_par_i,
  output logic                        corr_req_o
);

  localparam int PAY_W = 8 * trp_pkg::PAY_MAX_BYTES;

  // Query parser
  trp_pkg::trp_query_t query;
  logic                query_valid, query_err;

  trp_rx_parser u_rx (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .rx_data_i     (rx_data_i),
    .rx_valid_i    (rx_valid_i),
    .query_o       (query),
    .query_valid_o (query_valid),
    .error_o       (query_err)
  );

  // Control fields
  logic [31:0] ctrl, next_ctrl;
  logic        auto_en, osc_variant;
  logic [2:0]  cfg_base;
  logic [4:0]  const_en;

  assign auto_en     = ctrl[trp_pkg::CTRL_AUTO_BIT];
  assign osc_variant = ctrl[trp_pkg::CTRL_OSC_BIT];
  assign cfg_base    = ctrl[trp_pkg::CTRL_TB_LSB +: 3];
  assign const_en    = ctrl[trp_pkg::CTRL_EN_LSB +: 5];

  // Query classification
  logic       q_time, q_utc, q_corr, type_ok, q_bad;
  logic [2:0] q_sel;

  always_comb begin
    type_ok = (query.qtype == trp_pkg::TYPE_CFG) ||
              (query.qtype <= {5'h00, trp_pkg::CONST_LAST});
    q_sel   = (query.qtype == trp_pkg::TYPE_CFG) ? cfg_base : query.qtype[2:0];
    q_time  = query_valid && query.sub == trp_pkg::SUB_TIME;
    q_utc   = query_valid && query.sub == trp_pkg::SUB_UTC && type_ok;
    q_corr  = query_valid && query.sub == trp_pkg::SUB_CORR;
    q_bad   = query_err || (query_valid && query.sub == trp_pkg::SUB_UTC && !type_ok);
  end

  // Pending work
  trp_pkg::trp_tx_state_t state, next_state;
  logic       pps_q, pps_edge;
  logic       pend_time, next_pend_time, time_query, next_time_query;
  logic       pend_utc, next_pend_utc, next_corr_req;
  logic [2:0] utc_sel, next_utc_sel;
  logic       launch_time, launch_utc;

  assign pps_edge    = pps_i & ~pps_q;
  assign launch_time = (state == trp_pkg::TX_IDLE) && pend_time;
  assign launch_utc  = (state == trp_pkg::TX_IDLE) && !pend_time && pend_utc;

  always_comb begin
    // New events win over the clear by a launch in the same cycle
    next_pend_time  = (pend_time & ~launch_time) |
                      (pps_edge & (auto_en | time_query | q_time));
    next_time_query = (time_query | q_time) & ~pps_edge;
    next_pend_utc   = (pend_utc & ~launch_utc) | q_utc;
    next_utc_sel    = q_utc ? q_sel : utc_sel;
    next_corr_req   = q_corr & (|const_en[4:1]);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pps_q      <= 1'b0;
      pend_time  <= 1'b0;
      time_query <= 1'b0;
      pend_utc   <= 1'b0;
      utc_sel    <= 3'h0;
      corr_req_o <= 1'b0;
    end else begin
      pps_q      <= pps_i;
      pend_time  <= next_pend_time;
      time_query <= next_time_query;
      pend_utc   <= next_pend_utc;
      utc_sel    <= next_utc_sel;
      corr_req_o <= next_corr_req;
    end
  end

  // Payload images, most significant byte first
  logic [PAY_W-1:0]    time_pay, utc_pay;
  trp_pkg::trp_utc_par_t par;
  logic [31:0]         par_week_sec;

  always_comb begin
    time_pay = {time_i.seconds_into_week, time_i.week,
                time_i.hour, time_i.minute, time_i.second,
                time_i.month, time_i.day, time_i.year,
                4'h0, time_i.time_utc, time_i.time_base,
                4'h0, time_i.pps_utc, time_i.pps_base,
                6'h00, time_i.time_valid, time_i.utc_valid,
                time_i.utc_offset,
                osc_variant ? 32'h0000_0000 : time_i.quant_err,
                time_i.bias, time_i.bias_rate};
    // Parameters arrive from the broadcast decoder, never estimated here
    par      = utc_par_i[utc_sel];
    par_week_sec = (par.seconds_into_week > trp_pkg::WEEK_SEC_MAX) ?
                   trp_pkg::WEEK_SEC_MAX : par.seconds_into_week;
    // Invalid sets zero the fields so stale data never leaks out
    utc_pay  = {5'h00, utc_sel,
                7'h00, par.valid,
                par.valid ? par.week : 16'h0000,
                par.valid ? par_week_sec : 32'h0000_0000,
                par.valid ? par.leap_second_delta : 8'h00,
                par.valid ? par.offset_ns : 64'h0000_0000_0000_0000,
                {13{8'h00}}};
  end

  // Response sequencer
  logic [PAY_W-1:0] pay, next_pay;
  logic [5:0]       idx, next_idx, pay_len, next_pay_len;
  logic [7:0]       sub, next_sub;
  logic [15:0]      rlen, next_rlen;
  logic [7:0]       tx_byte, chk;
  logic             chk_en, clr, stage_ready;
  logic [5:0]       idx_chk;

  assign idx_chk = trp_pkg::PAY_IDX_FIRST + pay_len;

  always_comb begin
    next_state   = state;
    next_pay     = pay;
    next_idx     = idx;
    next_pay_len = pay_len;
    next_sub     = sub;
    next_rlen    = rlen;
    clr          = 1'b0;
    case (state)
      trp_pkg::TX_IDLE: begin
        if (launch_time) begin
          next_pay     = time_pay;
          next_pay_len = trp_pkg::PAY_TIME_BYTES;
          next_sub     = trp_pkg::SUB_TIME;
          next_rlen    = trp_pkg::LEN_TIME_RESP;
        end else if (launch_utc) begin
          next_pay     = utc_pay;
          next_pay_len = trp_pkg::PAY_UTC_BYTES;
          next_sub     = trp_pkg::SUB_UTC;
          next_rlen    = trp_pkg::LEN_UTC_RESP;
        end
        if (launch_time || launch_utc) begin
          next_idx   = 6'h00;
          clr        = 1'b1;
          next_state = trp_pkg::TX_SEND;
        end
      end
      trp_pkg::TX_SEND: begin
        if (stage_ready) begin
          next_idx = idx + 6'h01;
          if (idx >= trp_pkg::PAY_IDX_FIRST && idx < idx_chk) begin
            next_pay = {pay[PAY_W-9:0], 8'h00};
          end
          if (idx == idx_chk + 6'h02) next_state = trp_pkg::TX_IDLE;
        end
      end
      default: next_state = trp_pkg::TX_IDLE;
    endcase
  end

  always_comb begin
    chk_en  = 1'b1;
    tx_byte = pay[PAY_W-1 -: 8];
    if (idx == 6'h00) begin
      tx_byte = trp_pkg::DLE;
      chk_en  = 1'b0;
    end else if (idx == 6'h01) begin
      tx_byte = trp_pkg::MSG_ID;
    end else if (idx == 6'h02) begin
      tx_byte = sub;
    end else if (idx == 6'h03) begin
      tx_byte = rlen[15:8];
    end else if (idx == 6'h04) begin
      tx_byte = rlen[7:0];
    end else if (idx == 6'h05) begin
      tx_byte = trp_pkg::MODE_RESP;
    end else if (idx == idx_chk) begin
      tx_byte = chk;
      chk_en  = 1'b0;
    end else if (idx == idx_chk + 6'h01) begin
      tx_byte = trp_pkg::DLE;
      chk_en  = 1'b0;
    end else if (idx == idx_chk + 6'h02) begin
      tx_byte = trp_pkg::ETX;
      chk_en  = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state   <= trp_pkg::TX_IDLE;
      pay     <= '0;
      idx     <= 6'h00;
      pay_len <= 6'h00;
      sub     <= 8'h00;
      rlen    <= 16'h0000;
    end else begin
      state   <= next_state;
      pay     <= next_pay;
      idx     <= next_idx;
      pay_len <= next_pay_len;
      sub     <= next_sub;
      rlen    <= next_rlen;
    end
  end

  trp_tx_stage u_tx (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .byte_i     (tx_byte),
    .valid_i    (state == trp_pkg::TX_SEND),
    .chk_en_i   (chk_en),
    .clr_i      (clr),
    .ready_o    (stage_ready),
    .chk_o      (chk),
    .tx_data_o  (tx_data_o),
    .tx_valid_o (tx_valid_o),
    .tx_ready_i (tx_ready_i)
  );

  // Wishbone slave, one wait state, unmapped reads return zero
  logic        req, next_ack;
  logic [31:0] next_dat;
  logic [15:0] cnt_ok, next_cnt_ok, cnt_err, next_cnt_err;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_comb begin
    next_ack     = req;
    next_ctrl    = ctrl;
    next_dat     = 32'h0000_0000;
    next_cnt_ok  = cnt_ok + {15'h0000, q_time | q_utc | q_corr};
    next_cnt_err = cnt_err + {15'h0000, q_bad};
    // Write lands on the edge at which the master sees ack
    if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == trp_pkg::REG_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) next_ctrl[8*b +: 8] = wb_dat_i[8*b +: 8] & trp_pkg::CTRL_MASK[8*b +: 8];
      end
    end
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        trp_pkg::REG_CTRL:   next_dat = ctrl;
        trp_pkg::REG_STATUS: next_dat = {27'h000_0000, |const_en[4:1], pend_utc, time_query,
                                         pend_time, state == trp_pkg::TX_SEND};
        trp_pkg::REG_COUNT:  next_dat = {cnt_err, cnt_ok};
        default:             next_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl     <= trp_pkg::CTRL_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      cnt_ok   <= 16'h0000;
      cnt_err  <= 16'h0000;
    end else begin
      ctrl     <= next_ctrl;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      cnt_ok   <= next_cnt_ok;
      cnt_err  <= next_cnt_err;
    end
  end

endmodule

`default_nettype wire

// ---- test/trp_framer_props.sv ----
// Checker for response frames on the host link
`timescale 1ns/1ps
`default_nettype none
module trp_framer_props (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] tx_data_o,
  input wire logic       tx_valid_o,
  input wire logic       tx_ready_i,
  input wire logic       corr_req_o
);
  logic [7:0] idx, len, sub, chk;
  wire take = tx_valid_o && tx_ready_i;
  wire tail = idx > 8'h04;
  // Length only trusted once byte 4 has passed
  always_ff @(posedge clk_i) begin
    if (rst_i || (take && tail && idx == len + 8'h06)) idx <= 8'h00;
    else if (take) idx <= idx + 8'h01;
    if (take && idx == 8'h02) sub <= tx_data_o;
    if (take && idx == 8'h04) len <= tx_data_o;
    if (take) chk <= (idx == 8'h00) ? 8'h00 : chk ^ tx_data_o;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_frame_align: assert property ($rose(tx_valid_o) |-> idx == 8'h00)
    else $error("frame starts mid count");
  a_start_byte: assert property (take && idx == 8'h00 |-> tx_data_o == 8'h10)
    else $error("bad start byte");
  a_ident_byte: assert property (take && idx == 8'h01 |-> tx_data_o == 8'hA1)
    else $error("bad identifier");
  a_sub_known: assert property (take && idx == 8'h02 |-> tx_data_o < 8'h02)
    else $error("bad sub identifier");
  a_len_field: assert property (take && idx == 8'h04 |-> tx_data_o == (sub == 8'h00 ? 8'h20 : 8'h13))
    else $error("bad length");
  a_chk_byte: assert property (take && tail && idx == len + 8'h04 |-> tx_data_o == chk)
    else $error("bad checksum");
  a_end_bytes: assert property (take && tail && idx > len + 8'h04 |-> tx_data_o == (idx == len + 8'h05 ? 8'h10 : 8'h03))
    else $error("bad end bytes");
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("byte dropped while stalled");
  a_corr_pulse: assert property (corr_req_o |=> !corr_req_o)
    else $error("request longer than one cycle");
endmodule
`default_nettype wire

// ---- test/trp_host_model.sv ----
// Host controller model: sends queries, takes response bytes
`timescale 1ns/1ps
`default_nettype none
module trp_host_model (
  input  wire logic       clk_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic [7:0]      rx_data_o,
  output logic            rx_valid_o,
  output logic            tx_ready_o
);
  logic [7:0] got_q[$];
  logic [7:0] lfsr = 8'h5A;
  // Shifter stalls land anywhere in a frame
  assign tx_ready_o = !slow_i || lfsr[0];
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
  end
  always @(posedge clk_i) begin
    lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    if (tx_valid_i && tx_ready_o) got_q.push_back(tx_data_i);
  end
  task automatic send(input logic [7:0] sub, input logic [7:0] qt, input logic bad);
    logic [7:0] f[$];
    logic [7:0] c;
    f = {8'h10, 8'hA1, sub, 8'h00, (sub == 8'h01) ? 8'h03 : 8'h02, 8'h00};
    if (sub == 8'h01) f.push_back(qt);
    c = 8'h00;
    foreach (f[i]) if (i > 0) c ^= f[i];
    f = {f, bad ? ~c : c, 8'h10, 8'h03};
    foreach (f[i]) begin
      @(posedge clk_i);
      rx_data_o <= f[i];
      rx_valid_o <= 1'b1;
    end
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~rx_data_o;  // Released line shows no stale byte
  endtask
endmodule
`default_nettype wire

// ---- test/trp_framer_tb.sv ----
// Bench: host model, register reads, frame models and compares
`timescale 1ns/1ps
`default_nettype none
module trp_framer_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, pps = 1'b0, slow = 1'b0;
  logic ack, rxv, txv, txr, corr;
  logic [7:0] adr = 8'h00, rxd, txd;
  logic [31:0] dato = 32'h0000_0000, dati, rd, rnd = 32'h0000_37c2;
  logic [639:0] r;
  logic [7:0] pq[$];
  logic [7:0] qt[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'hFF};
  trp_pkg::trp_time_rpt_t tm = '0;
  trp_pkg::trp_utc_par_t [4:0] up = '0;
  int fails = 0, total_checks = 0, cyc_n = 0, corr_n = 0, n0;
  always #2 clk_i = ~clk_i;
  trp_framer dut_u (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dato), .wb_dat_o(dati), .wb_ack_o(ack), .rx_data_i(rxd), .rx_valid_i(rxv),
    .tx_data_o(txd), .tx_valid_o(txv), .tx_ready_i(txr), .pps_i(pps), .time_i(tm), .utc_par_i(up),
    .corr_req_o(corr));
  trp_host_model host_u (.clk_i, .slow_i(slow), .tx_data_i(txd), .tx_valid_i(txv), .rx_data_o(rxd),
    .rx_valid_o(rxv), .tx_ready_o(txr));
  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmp32(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dato <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dati;
    cyc <= 1'b0;
  endtask
  task automatic put(input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) pq.push_back(v[8*i +: 8]);
  endtask
  task automatic shuffle();
    @(posedge clk_i);
    for (int i = 0; i < 20; i++) r[32*i +: 32] = xs();
    tm <= r[639 -: $bits(tm)];
    up <= r[$bits(up)-1:0];
    slow <= r[0];
  endtask
  task automatic pulse();
    @(posedge clk_i);
    pps <= 1'b1;
    repeat (3) @(posedge clk_i);
    pps <= 1'b0;
  endtask
  task automatic frame_check(input logic [7:0] sub, input string n);
    logic [7:0] e[$];
    logic [7:0] c;
    e = {8'h10, 8'hA1, sub, 8'h00, 8'(pq.size() + 2), 8'h02, pq};
    c = 8'h00;
    foreach (e[i]) if (i > 0) c ^= e[i];
    e = {e, c, 8'h10, 8'h03};
    for (int i = 0; i < 400 && host_u.got_q.size() < e.size(); i++) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
    cmp32(n, e.size(), host_u.got_q.size());
    foreach (e[i]) cmp8(n, e[i], i < host_u.got_q.size() ? host_u.got_q[i] : 8'hxx);
    host_u.got_q.delete();
    pq.delete();
    $display("%s done", n);
  endtask
  task automatic time_pay(input logic osc);
    put({tm.seconds_into_week, tm.week}, 6);
    put({tm.hour, tm.minute, tm.second, tm.month, tm.day, tm.year}, 7);
    put({4'h0, tm.time_utc, tm.time_base, 4'h0, tm.pps_utc, tm.pps_base}, 2);
    put({6'h00, tm.time_valid, tm.utc_valid, tm.utc_offset}, 3);
    put(osc ? 32'h0000_0000 : tm.quant_err, 4);
    put({tm.bias, tm.bias_rate}, 8);
  endtask
  task automatic utc_pay(input logic [7:0] q);
    trp_pkg::trp_utc_par_t p;
    logic [2:0] k;
    k = (q == 8'hFF) ? 3'h3 : q[2:0];
    p = up[k];
    if (!p.valid) p = '0;
    if (p.seconds_into_week > trp_pkg::WEEK_SEC_MAX) p.seconds_into_week = trp_pkg::WEEK_SEC_MAX;
    put({5'h00, k, 7'h00, p.valid}, 2);
    put({p.week, p.seconds_into_week, p.leap_second_delta}, 7);
    put(p.offset_ns, 8);
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (corr === 1'b1) corr_n++;
    if (cyc_n == 6000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0000_0000);
    cmp32("ctrl", 32'h0000_0101, rd);
    for (int a = 4; a <= 12; a += 4) begin
      wb(1'b0, 8'(a), 32'h0000_0000);
      cmp32("reg", 32'h0000_0000, rd);
    end
    $display("registers done");
    shuffle();
    pulse();
    time_pay(1'b0);
    frame_check(8'h00, "auto report");
    wb(1'b1, 8'h00, 32'h0000_0102);
    shuffle();
    host_u.send(8'h00, 8'h00, 1'b0);
    repeat (30) @(posedge clk_i);
    cmp32("early bytes", 0, host_u.got_q.size());
    pulse();
    time_pay(1'b1);
    frame_check(8'h00, "queried report");
    pulse();
    repeat (30) @(posedge clk_i);
    cmp32("unprompted bytes", 0, host_u.got_q.size());
    wb(1'b1, 8'h00, 32'h0000_0130);
    foreach (qt[i]) begin
      shuffle();
      host_u.send(8'h01, qt[i], 1'b0);
      utc_pay(qt[i]);
      frame_check(8'h01, "offset report");
    end
    n0 = corr_n;
    host_u.send(8'h02, 8'h00, 1'b0);
    repeat (8) @(posedge clk_i);
    cmp32("gps only corr", n0, corr_n);
    wb(1'b1, 8'h00, 32'h0000_0300);
    host_u.send(8'h02, 8'h00, 1'b0);
    repeat (8) @(posedge clk_i);
    cmp32("corr request", n0 + 1, corr_n);
    host_u.send(8'h01, 8'h02, 1'b1);
    repeat (30) @(posedge clk_i);
    cmp32("bad frame bytes", 0, host_u.got_q.size());
    host_u.send(8'h01, 8'h05, 1'b0);
    repeat (30) @(posedge clk_i);
    cmp32("bad type bytes", 0, host_u.got_q.size());
    wb(1'b0, 8'h04, 32'h0000_0000);
    cmp32("status", 32'h0000_0010, rd);
    wb(1'b1, 8'h08, 32'hFFFF_FFFF);
    wb(1'b0, 8'h08, 32'h0000_0000);
    cmp32("count", 32'h0002_0009, rd);
    wb(1'b1, 8'h00, 32'hFFFF_FFFF);
    wb(1'b0, 8'h00, 32'h0000_0000);
    cmp32("ctrl mask", 32'h0000_1F73, rd);
    $display("queries done");
    end_of_test();
  end
endmodule
bind trp_framer trp_framer_props chk_u (.clk_i, .rst_i, .tx_data_o, .tx_valid_o, .tx_ready_i, .corr_req_o);
`default_nettype wire
